/* common/eps_pkg.sv */
package eps_pkg;

  // Clocking: system clock and nominal internal oscillator
  localparam int          CLK_HZ        = 20_000_000;
  localparam int          OSC_HZ        = 450_000;
  localparam int          PH_W          = 25;
  localparam int          MS_PER_S      = 1_000;
  localparam longint      NS_PER_S      = 1_000_000_000;

  // Pulse timing in printed units
  localparam int          T_LR_THRESH_MS = 1062;
  localparam int          T_CF_WIDTH_MS  = 173;
  localparam int          T_CF_THRESH_MS = 346;
  localparam int          T_HF_WIDTH_NS  = 35_000;

  // Pulse timing in clock cycles (longest times round down, least round up)
  localparam longint LR_THRESH_CYC_DEF = (longint'(T_LR_THRESH_MS) * CLK_HZ) / MS_PER_S;
  localparam longint LR_WIDTH_CYC_DEF  = LR_THRESH_CYC_DEF / 2;
  localparam longint CF_WIDTH_CYC_DEF  = (longint'(T_CF_WIDTH_MS) * CLK_HZ) / MS_PER_S;
  localparam longint CF_THRESH_CYC_DEF = (longint'(T_CF_THRESH_MS) * CLK_HZ) / MS_PER_S;
  localparam longint HF_WIDTH_CYC      =
    (longint'(T_HF_WIDTH_NS) * CLK_HZ + NS_PER_S - 1) / NS_PER_S;

  // Power path and frequency scaling
  localparam int          POW_W         = 16;
  localparam int          POW_FS_EXP    = 15;
  localparam int          BASE_DIV_MAX  = 19;
  localparam int          ACC_W         = 40;
  localparam int          NOLOAD_PPM    = 14;
  localparam int          PPM_DEN       = 1_000_000;
  localparam int          NOLOAD_MIN    =
    ((1 << POW_FS_EXP) * NOLOAD_PPM + PPM_DEN - 1) / PPM_DEN;

  // Strap code {calib_scale_sel, rate_sel_hi, rate_sel_lo}
  localparam logic [2:0]  CODE_HF       = 3'h3;

  // Register map (byte addresses)
  localparam logic [7:0]  REG_CTRL      = 8'h00;
  localparam logic [7:0]  REG_STATUS    = 8'h04;
  localparam logic [7:0]  REG_IRQ_STAT  = 8'h08;
  localparam logic [7:0]  REG_IRQ_MASK  = 8'h0C;
  localparam logic [7:0]  REG_EQ_COUNT  = 8'h10;

  // Field positions
  localparam int          CTRL_EN_BIT   = 0;
  localparam logic        CTRL_EN_RST   = 1'b1;
  localparam int          ST_CODE_LSB   = 0;
  localparam int          ST_REV_BIT    = 3;
  localparam int          ST_SIDE_BIT   = 4;
  localparam int          ST_LOAD_BIT   = 5;
  localparam int          IRQ_W         = 3;
  localparam int          IRQ_CF_BIT    = 0;
  localparam int          IRQ_EQ_BIT    = 1;
  localparam int          IRQ_REV_BIT   = 2;

  // Log2 of the calibration-to-low-rate multiplier for a strap code
  function automatic logic [3:0] eps_calib_shift(input logic [2:0] code);
    case (code)
      3'h4:    eps_calib_shift = 4'h7;
      3'h0:    eps_calib_shift = 4'h6;
      3'h5:    eps_calib_shift = 4'h6;
      3'h1:    eps_calib_shift = 4'h5;
      3'h6:    eps_calib_shift = 4'h5;
      3'h2:    eps_calib_shift = 4'h4;
      3'h7:    eps_calib_shift = 4'h4;
      default: eps_calib_shift = 4'hB;
    endcase
  endfunction

endpackage

/* core/eps_pulse_stretch.sv */
`timescale 1ns/100ps
`default_nettype none
module eps_pulse_stretch
  import eps_pkg::*;
#(
  parameter int CNT_W = 26
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             sys_rst,
  // Pulse request and width settings
  input  wire logic             fire,
  input  wire logic [CNT_W-1:0] width_fixed,
  input  wire logic [CNT_W-1:0] period_thresh,
  input  wire logic             short_en,
  input  wire logic [CNT_W-1:0] width_short,
  // Shaped pulse, active high
  output logic                  active_q
);

  logic [CNT_W-1:0] per_q;
  logic [CNT_W-1:0] wid_q;
  logic [CNT_W-1:0] wid_d;
  logic [CNT_W-1:0] half_per;

  assign half_per = per_q >> 1;

  // Width chosen at the fire edge from the interval just ended
  always_comb
  begin
    if (short_en)
      wid_d = width_short;
    else if ((per_q < period_thresh) && (half_per != '0))
      wid_d = half_per;
    else
      wid_d = width_fixed;
  end

  // Interval since the previous request, saturating so the first pulse is full width
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      per_q <= '1;
    else if (fire)
      per_q <= CNT_W'(1);
    else if (per_q != '1)
      per_q <= per_q + CNT_W'(1);
  end

  // Width down-counter; a new request restarts the pulse
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      wid_q    <= '0;
      active_q <= 1'b0;
    end
    else if (fire)
    begin
      wid_q    <= wid_d - CNT_W'(1);
      active_q <= 1'b1;
    end
    else if (wid_q != '0)
      wid_q <= wid_q - CNT_W'(1);
    else
      active_q <= 1'b0;
  end

  // Helper: length of the pulse now running and the width it was given
  logic [CNT_W-1:0] run_q;
  logic [CNT_W-1:0] want_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      run_q  <= '0;
      want_q <= '0;
    end
    else if (fire)
    begin
      run_q  <= CNT_W'(1);
      want_q <= wid_d;
    end
    else if (active_q)
      run_q <= run_q + CNT_W'(1);
  end

  AST_WIDTH_EXACT: assert property (@(posedge clk) disable iff (sys_rst)
    ($fell(active_q) && !$past(fire)) |-> ($past(run_q) == $past(want_q)))
    else $error("pulse width differs from the width chosen at fire");

  AST_HALF_PERIOD: assert property (@(posedge clk) disable iff (sys_rst)
    (fire && !short_en && (per_q < period_thresh) && ((per_q >> 1) != '0))
      |=> (want_q == ($past(per_q) >> 1)))
    else $error("short period did not give a half-period width");

  AST_SHORT_WIDTH: assert property (@(posedge clk) disable iff (sys_rst)
    (fire && short_en) |=> (active_q && (want_q == $past(width_short))))
    else $error("high-frequency width not applied");

endmodule
`default_nettype wire

/* core/eps_energy_pulse_output_shaper.sv */
`timescale 1ns/100ps
`default_nettype none
module eps_energy_pulse_output_shaper
  import eps_pkg::*;
#(
  parameter int CNT_W         = 26,
  parameter int LR_THRESH_CYC = int'(LR_THRESH_CYC_DEF),
  parameter int LR_WIDTH_CYC  = int'(LR_WIDTH_CYC_DEF),
  parameter int CF_THRESH_CYC = int'(CF_THRESH_CYC_DEF),
  parameter int CF_WIDTH_CYC  = int'(CF_WIDTH_CYC_DEF)
)(
  // Clock and reset
  input  wire logic                    clk,
  input  wire logic                    sys_rst,
  // Filtered real power from the multiplier, same clock
  input  wire logic signed [POW_W-1:0] power_val,
  // Strap pins
  input  wire logic                    rate_sel_lo,
  input  wire logic                    rate_sel_hi,
  input  wire logic                    calib_scale_sel,
  // Pulse outputs
  output logic                         energy_pulse_a_n,
  output logic                         energy_pulse_b_n,
  output logic                         calib_pulse,
  output logic                         reverse_power_flag,
  // Wishbone slave
  input  wire logic [7:0]              wb_adr_i,
  input  wire logic [31:0]             wb_dat_i,
  input  wire logic [3:0]              wb_sel_i,
  input  wire logic                    wb_we_i,
  input  wire logic                    wb_cyc_i,
  input  wire logic                    wb_stb_i,
  output logic [31:0]                  wb_dat_o,
  output logic                         wb_ack_o,
  // Interrupt
  output logic                         irq
);

  // Straps come from pins: two flip-flops before use
  logic [2:0] strap_meta_q;
  logic [2:0] code_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      strap_meta_q <= '0;
      code_q       <= '0;
    end
    else
    begin
      strap_meta_q <= {calib_scale_sel, rate_sel_hi, rate_sel_lo};
      code_q       <= strap_meta_q;
    end
  end

  logic       hf_mode;
  logic [3:0] cal_shift;
  assign hf_mode   = (code_q == CODE_HF);
  assign cal_shift = eps_calib_shift(code_q);

  // Oscillator tick: fractional divider so every rate tracks the nominal oscillator
  logic [PH_W-1:0] phase_q;
  logic [PH_W-1:0] phase_sum;
  logic            osc_tick;
  assign phase_sum = phase_q + PH_W'(OSC_HZ);
  assign osc_tick  = (phase_sum >= PH_W'(CLK_HZ));
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      phase_q <= '0;
    else if (osc_tick)
      phase_q <= phase_sum - PH_W'(CLK_HZ);
    else
      phase_q <= phase_sum;
  end

  // Control register bits
  logic ctrl_en_q;

  // Magnitude and sign of power; negative means phase beyond a right angle
  logic [POW_W-1:0] pow_mag;
  logic             pow_neg;
  logic             above_min;
  assign pow_neg   = power_val[POW_W-1];
  assign pow_mag   = pow_neg ? POW_W'(-power_val) : POW_W'(power_val);
  assign above_min = (pow_mag >= POW_W'(NOLOAD_MIN));

  // Calibration quantum: base-rate division times multiplier, as one shift
  logic [5:0]       q_exp;
  logic [ACC_W-1:0] quantum;
  assign q_exp   = 6'(POW_FS_EXP + BASE_DIV_MAX) - 6'({code_q[1:0]}) - 6'(cal_shift);
  assign quantum = ACC_W'(1) << q_exp;

  // Energy accumulator; below the no-load minimum nothing accumulates
  logic [ACC_W-1:0] acc_q;
  logic [ACC_W-1:0] acc_sum;
  logic             acc_go;
  logic             cf_hit;
  assign acc_go  = osc_tick && ctrl_en_q && above_min;
  assign acc_sum = acc_q + ACC_W'(pow_mag);
  assign cf_hit  = acc_go && (acc_sum >= quantum);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      acc_q <= '0;
    else if (cf_hit)
      acc_q <= acc_sum - quantum;
    else if (acc_go)
      acc_q <= acc_sum;
  end

  // Calibration pulses per low-rate quantum
  logic [11:0] cf_cnt_q;
  logic [11:0] cf_last;
  logic        eq_hit;
  assign cf_last = 12'((13'h1 << cal_shift) - 13'h1);
  assign eq_hit  = cf_hit && (cf_cnt_q >= cf_last);
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      cf_cnt_q <= '0;
    else if (eq_hit)
      cf_cnt_q <= '0;
    else if (cf_hit)
      cf_cnt_q <= cf_cnt_q + 12'h001;
  end

  // Side selector: flips per quantum so the outputs alternate
  logic side_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      side_q <= 1'b0;
    else if (eq_hit)
      side_q <= ~side_q;
  end

  // Reverse flag only moves with a calibration pulse
  logic rev_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      rev_q <= 1'b0;
    else if (cf_hit)
      rev_q <= pow_neg;
  end
  assign reverse_power_flag = rev_q;

  // Pulse shaping: one stretcher shared by both low-rate outputs, one for calibration
  logic lr_active;
  logic cf_active;
  eps_pulse_stretch #(.CNT_W(CNT_W)) u_lr_stretch (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .fire          (eq_hit),
    .width_fixed   (CNT_W'(LR_WIDTH_CYC)),
    .period_thresh (CNT_W'(LR_THRESH_CYC)),
    .short_en      (1'b0),
    .width_short   ('0),
    .active_q      (lr_active)
  );
  eps_pulse_stretch #(.CNT_W(CNT_W)) u_cf_stretch (
    .clk           (clk),
    .sys_rst       (sys_rst),
    .fire          (cf_hit),
    .width_fixed   (CNT_W'(CF_WIDTH_CYC)),
    .period_thresh (CNT_W'(CF_THRESH_CYC)),
    .short_en      (hf_mode),
    .width_short   (CNT_W'(HF_WIDTH_CYC)),
    .active_q      (cf_active)
  );

  // Output flops; low-rate pins idle high and pull low per quantum
  logic ep_a_q;
  logic ep_b_q;
  logic cf_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
    begin
      ep_a_q <= 1'b1;
      ep_b_q <= 1'b1;
      cf_q   <= 1'b0;
    end
    else
    begin
      ep_a_q <= ~(lr_active & side_q);
      ep_b_q <= ~(lr_active & ~side_q);
      cf_q   <= cf_active;
    end
  end
  assign energy_pulse_a_n = ep_a_q;
  assign energy_pulse_b_n = ep_b_q;
  assign calib_pulse      = cf_q;

  // Count of issued energy quanta for software
  logic [31:0] eq_count_q;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      eq_count_q <= '0;
    else if (eq_hit)
      eq_count_q <= eq_count_q + 32'h00000001;
  end

  // Wishbone: registered ack one cycle after the request, ack drops the cycle after it rises
  logic wb_req;
  logic wb_wr;
  assign wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wb_wr  = wb_req && wb_we_i && wb_sel_i[0];
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wb_ack_o <= 1'b0;
    else
      wb_ack_o <= wb_req;
  end

  // Control register; enable gates the accumulator
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      ctrl_en_q <= CTRL_EN_RST;
    else if (wb_wr && (wb_adr_i == REG_CTRL))
      ctrl_en_q <= wb_dat_i[CTRL_EN_BIT];
  end

  // Interrupt status: sticky, write one to clear, a new event beats the clear
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [IRQ_W-1:0] irq_set;
  logic [IRQ_W-1:0] irq_clr;
  always_comb
  begin
    irq_set              = '0;
    irq_set[IRQ_CF_BIT]  = cf_hit;
    irq_set[IRQ_EQ_BIT]  = eq_hit;
    irq_set[IRQ_REV_BIT] = cf_hit && (pow_neg != rev_q);
  end
  assign irq_clr = (wb_wr && (wb_adr_i == REG_IRQ_STAT)) ? wb_dat_i[IRQ_W-1:0] : '0;
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_set;
  end

  // Mask register, same layout as status
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq_mask_q <= '0;
    else if (wb_wr && (wb_adr_i == REG_IRQ_MASK))
      irq_mask_q <= wb_dat_i[IRQ_W-1:0];
  end

  // Registered so the level never glitches on a clear
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      irq <= 1'b0;
    else
      irq <= |(((irq_stat_q & ~irq_clr) | irq_set) & irq_mask_q);
  end

  // Read data captured with the ack; unmapped offsets read zero
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      wb_dat_o <= '0;
    else if (wb_req)
    begin
      wb_dat_o <= '0;
      case (wb_adr_i)
        REG_CTRL:
          wb_dat_o[CTRL_EN_BIT] <= ctrl_en_q;
        REG_STATUS:
        begin
          wb_dat_o[ST_CODE_LSB +: 3] <= code_q;
          wb_dat_o[ST_REV_BIT]       <= rev_q;
          wb_dat_o[ST_SIDE_BIT]      <= side_q;
          wb_dat_o[ST_LOAD_BIT]      <= above_min;
        end
        REG_IRQ_STAT:
          wb_dat_o[IRQ_W-1:0] <= irq_stat_q;
        REG_IRQ_MASK:
          wb_dat_o[IRQ_W-1:0] <= irq_mask_q;
        REG_EQ_COUNT:
          wb_dat_o <= eq_count_q;
        default:
          wb_dat_o <= '0;
      endcase
    end
  end

  // Checks next to the logic they guard
  AST_STRAP_PATH: assert property (@(posedge clk) disable iff (sys_rst)
    ##2 (code_q == $past({calib_scale_sel, rate_sel_hi, rate_sel_lo}, 2)))
    else $error("strap code not taken through two stages");

  AST_NEVER_BOTH: assert property (@(posedge clk) disable iff (sys_rst)
    !(!energy_pulse_a_n && !energy_pulse_b_n))
    else $error("both low-rate outputs active together");

  AST_ALT_SIDE: assert property (@(posedge clk) disable iff (sys_rst)
    (eq_hit && !side_q) |-> ##2 (!energy_pulse_a_n && energy_pulse_b_n))
    else $error("quantum did not appear on the expected output");

  AST_CREEP_BLOCK: assert property (@(posedge clk) disable iff (sys_rst)
    (!above_min || !ctrl_en_q) |=> ($stable(acc_q) && !$past(cf_hit)))
    else $error("accumulation below the no-load minimum");

  AST_RATIO_64: assert property (@(posedge clk) disable iff (sys_rst)
    (code_q == 3'h5) |-> (cf_last == 12'h03F))
    else $error("wrong calibration multiplier for this strap code");

  AST_QUANTUM_SUB: assert property (@(posedge clk) disable iff (sys_rst)
    cf_hit |=> (acc_q == $past(acc_sum) - $past(quantum)))
    else $error("quantum not removed from the accumulator");

  AST_REV_ONLY_CF: assert property (@(posedge clk) disable iff (sys_rst)
    !cf_hit |=> $stable(reverse_power_flag))
    else $error("reverse flag moved between calibration pulses");

  AST_REV_SIGN: assert property (@(posedge clk) disable iff (sys_rst)
    cf_hit |=> (reverse_power_flag == $past(pow_neg)))
    else $error("reverse flag does not follow the power sign");

  AST_CF_FOLLOWS: assert property (@(posedge clk) disable iff (sys_rst)
    cf_hit |-> ##2 calib_pulse)
    else $error("calibration pulse not issued after a quantum");

  AST_ACK_ONE: assert property (@(posedge clk) disable iff (sys_rst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  COV_EQ_A: cover property (@(posedge clk) disable iff (sys_rst) $fell(energy_pulse_a_n));
  COV_EQ_B: cover property (@(posedge clk) disable iff (sys_rst) $fell(energy_pulse_b_n));
  COV_REV:  cover property (@(posedge clk) disable iff (sys_rst) $rose(reverse_power_flag));
  COV_HF:   cover property (@(posedge clk) disable iff (sys_rst) hf_mode && cf_hit);

endmodule
`default_nettype wire

/* tb/eps_counter_model.sv */
`timescale 1ns/100ps
`default_nettype none
module eps_counter_model
(
  // Clock and reset
  input  wire logic  clk,
  input  wire logic  sys_rst,
  // Pulse lines from the shaper
  input  wire logic  pulse_a_n,
  input  wire logic  pulse_b_n,
  input  wire logic  calib_pulse,
  // Measurements
  output logic        cf_done,
  output logic [31:0] cf_width,
  output logic [31:0] cf_period,
  output logic [31:0] cf_count,
  output logic [31:0] quanta,
  output logic        alt_err
);
  logic [31:0] hi_cnt;
  logic [31:0] since;
  logic        cp_q;
  logic        a_q;
  logic        b_q;
  logic        next_b;

  // Counter input: time each calibration pulse and step on each low-going quantum
  always_ff @(posedge clk)
  begin
    cp_q    <= calib_pulse;
    a_q     <= pulse_a_n;
    b_q     <= pulse_b_n;
    cf_done <= cp_q & ~calib_pulse;
    since   <= since + 32'h1;
    hi_cnt  <= calib_pulse ? hi_cnt + 32'h1 : 32'h0;
    if (cp_q & ~calib_pulse)
      cf_width <= hi_cnt;
    if (~cp_q & calib_pulse)
    begin
      cf_period <= since;
      since     <= 32'h1;
      cf_count  <= cf_count + 32'h1;
    end
    // A stepper only turns if the coils alternate, so a repeat is an error
    if (a_q & ~pulse_a_n)
    begin
      alt_err <= alt_err | next_b;
      next_b  <= 1'b1;
      quanta  <= quanta + 32'h1;
    end
    if (b_q & ~pulse_b_n)
    begin
      alt_err <= alt_err | ~next_b;
      next_b  <= 1'b0;
      quanta  <= quanta + 32'h1;
    end
    if (sys_rst)
    begin
      cf_count <= 32'h0;
      quanta   <= 32'h0;
      alt_err  <= 1'b0;
      next_b   <= 1'b0;
      since    <= 32'h0;
      cf_width <= 32'h0;
    end
  end
endmodule
`default_nettype wire

/* tb/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top
  import eps_pkg::*;
;
  logic                    clk             = 1'b0;
  logic                    sys_rst         = 1'b1;
  logic signed [POW_W-1:0] power_val       = '0;
  logic                    rate_sel_lo     = 1'b0;
  logic                    rate_sel_hi     = 1'b0;
  logic                    calib_scale_sel = 1'b0;
  logic [7:0]              wb_adr_i        = 8'h00;
  logic [31:0]             wb_dat_i        = 32'h0;
  logic [3:0]              wb_sel_i        = 4'h0;
  logic                    wb_we_i         = 1'b0;
  logic                    wb_cyc_i        = 1'b0;
  logic                    wb_stb_i        = 1'b0;
  logic [31:0]             wb_dat_o;
  logic                    wb_ack_o;
  logic                    energy_pulse_a_n;
  logic                    energy_pulse_b_n;
  logic                    calib_pulse;
  logic                    reverse_power_flag;
  logic                    irq;
  logic                    cf_done;
  logic [31:0]             cf_width;
  logic [31:0]             cf_period;
  logic [31:0]             cf_count;
  logic [31:0]             quanta;
  logic                    alt_err;
  logic [31:0]             exp_q[$];
  logic [31:0]             msk_q[$];
  logic [31:0]             n0;
  logic                    per_ok  = 1'b0;
  logic                    rev_d   = 1'b0;
  logic                    cp_d    = 1'b0;
  logic                    rise    = 1'b0;
  logic                    rise_d  = 1'b0;
  logic                    rev_chg = 1'b0;
  real                     exp_per = 1.0;
  int                      bad_count   = 0;
  int                      comparisons = 0;
  int                      cycles      = 0;
  int                      seed;

  eps_energy_pulse_output_shaper #(.CNT_W(26), .LR_THRESH_CYC(400), .LR_WIDTH_CYC(200),
    .CF_THRESH_CYC(200), .CF_WIDTH_CYC(100)) eps_energy_pulse_output_shaper_i (
    .clk(clk), .sys_rst(sys_rst), .power_val(power_val), .rate_sel_lo(rate_sel_lo),
    .rate_sel_hi(rate_sel_hi), .calib_scale_sel(calib_scale_sel),
    .energy_pulse_a_n(energy_pulse_a_n), .energy_pulse_b_n(energy_pulse_b_n),
    .calib_pulse(calib_pulse), .reverse_power_flag(reverse_power_flag),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .irq(irq));

  eps_counter_model eps_counter_model_i (
    .clk(clk), .sys_rst(sys_rst), .pulse_a_n(energy_pulse_a_n), .pulse_b_n(energy_pulse_b_n),
    .calib_pulse(calib_pulse), .cf_done(cf_done), .cf_width(cf_width),
    .cf_period(cf_period), .cf_count(cf_count), .quanta(quanta), .alt_err(alt_err));

  // 20 MHz clock
  always #25 clk = ~clk;

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Hang guard well above the planned run of some 50k cycles
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 100000)
    begin
      bad_count++;
      test_done();
    end
  end

  // Scoreboard: reads against the oldest note, pulses against current settings
  always @(posedge clk)
  begin
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
      check("read data", wb_dat_o & msk_q.pop_front(), exp_q.pop_front());
    if (cf_done === 1'b1)
      check("cf width", cf_width, 32'(HF_WIDTH_CYC));
    if (cf_done === 1'b1 && per_ok)
    begin
      check("reverse flag", {31'h0, reverse_power_flag}, {31'h0, power_val[POW_W-1]});
      check("cf period", {31'h0, cf_period > 0.95 * exp_per && cf_period < 1.05 * exp_per},
        32'h1);
    end
    // The flag may only move together with a calibration pulse starting
    rise = calib_pulse & ~cp_d;
    if (rev_chg)
      check("flag move", {31'h0, rise | rise_d}, 32'h1);
    rev_chg = (reverse_power_flag !== rev_d) && sys_rst === 1'b0;
    rev_d   = reverse_power_flag;
    cp_d    = calib_pulse;
    rise_d  = rise;
  end

  // Classic single cycle; held until ack is sampled, then released for a cycle
  task automatic wb_cycle(input logic we, input logic [7:0] adr, input logic [31:0] dat,
    input logic [3:0] sel);
    int n;
    n = 0;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    wb_sel_i <= sel;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wb_ack_o !== 1'b1 && n < 100);
    if (n >= 100)
      bad_count++;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [7:0] adr, input logic [31:0] msk, input logic [31:0] exp);
    exp_q.push_back(exp & msk);
    msk_q.push_back(msk);
    wb_cycle(1'b0, adr, 32'h0, 4'hF);
  endtask

  task automatic wait_cf(input int n);
    int          k;
    logic [31:0] c0;
    c0 = cf_count;
    k = 0;
    while (cf_count < c0 + n && k < 4000 * n)
    begin
      @(posedge clk);
      k++;
    end
    check("cf arrives", {31'h0, k < 4000 * n}, 32'h1);
  endtask

  // Period is judged only after two pulses, once the old accumulation has drained
  task automatic run_power(input logic signed [POW_W-1:0] p, input int n);
    per_ok    <= 1'b0;
    power_val <= p;
    exp_per = 1048576.0 * CLK_HZ / (real'(OSC_HZ) * real'(p < 0 ? -p : p));
    wait_cf(2);
    per_ok <= 1'b1;
    wait_cf(n);
    per_ok <= 1'b0;
  endtask

  initial
  begin
    seed = $urandom(32913);
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    check("pins idle", {29'h0, energy_pulse_a_n, energy_pulse_b_n, calib_pulse}, 32'h6);
    rd(REG_CTRL, 32'h1, 32'h1);
    rd(REG_IRQ_MASK, 32'h7, 32'h0);
    rd(8'h20, 32'hFFFFFFFF, 32'h0);
    wb_cycle(1'b1, 8'h20, 32'hFFFFFFFF, 4'hF);
    wb_cycle(1'b1, REG_IRQ_MASK, 32'h7, 4'hE);
    rd(REG_IRQ_MASK, 32'h7, 32'h0);
    // Every strap code reaches the status field
    for (int c = 0; c < 8; c++)
    begin
      {calib_scale_sel, rate_sel_hi, rate_sel_lo} <= 3'(c);
      repeat (4) @(posedge clk);
      rd(REG_STATUS, 32'h7, 32'(c));
    end
    wb_cycle(1'b1, REG_STATUS, 32'h0, 4'hF);
    rd(REG_STATUS, 32'h7, 32'h7);
    {calib_scale_sel, rate_sel_hi, rate_sel_lo} <= CODE_HF;
    wb_cycle(1'b1, REG_IRQ_MASK, 32'h1, 4'hF);
    wb_cycle(1'b1, REG_IRQ_STAT, 32'h7, 4'hF);
    run_power(16'sh7FFF, 3);
    repeat (3) @(posedge clk);
    check("irq raised", {31'h0, irq}, 32'h1);
    rd(REG_IRQ_STAT, 32'h1, 32'h1);
    wb_cycle(1'b1, REG_IRQ_STAT, 32'h1, 4'hF);
    repeat (2) @(posedge clk);
    check("irq cleared", {31'h0, irq}, 32'h0);
    rd(REG_STATUS, 32'h28, 32'h20);
    // Negative power, then random positive loads
    run_power(-16'sh7FFF, 3);
    rd(REG_STATUS, 32'h28, 32'h28);
    rd(REG_IRQ_STAT, 32'h4, 32'h4);
    repeat (3) run_power(16'(16384 + $urandom % 16384), 2);
    // Masked event leaves irq low but sets the sticky bit
    wb_cycle(1'b1, REG_IRQ_MASK, 32'h0, 4'hF);
    wb_cycle(1'b1, REG_IRQ_STAT, 32'h7, 4'hF);
    wait_cf(1);
    repeat (3) @(posedge clk);
    check("irq masked", {31'h0, irq}, 32'h0);
    rd(REG_IRQ_STAT, 32'h1, 32'h1);
    // No load: nothing issues
    power_val <= '0;
    repeat (2000) @(posedge clk);
    n0 = cf_count;
    repeat (4000) @(posedge clk);
    check("no-load count", cf_count, n0);
    rd(REG_STATUS, 32'h20, 32'h0);
    // Disable first, then load, so no tick can slip in before the enable drops
    wb_cycle(1'b1, REG_CTRL, 32'h0, 4'hF);
    power_val <= 16'sh7FFF;
    n0 = cf_count;
    repeat (4000) @(posedge clk);
    check("disabled count", cf_count, n0);
    rd(REG_CTRL, 32'h1, 32'h0);
    wb_cycle(1'b1, REG_CTRL, 32'h1, 4'hF);
    wait_cf(1);
    // Far fewer than 2048 cf events so far: no low-rate quantum yet
    check("quanta", quanta, 32'h0);
    rd(REG_EQ_COUNT, 32'hFFFFFFFF, 32'h0);
    check("alternation", {31'h0, alt_err}, 32'h0);
    repeat (3) @(posedge clk);
    test_done();
  end
endmodule
`default_nettype wire
